// *** common/ctc_fifo_if.sv ***
// Purpose: storage port between compensation logic and its memory
// Assumes: single core clock for both ports
// Notes:   read data is registered inside the memory
interface ctc_fifo_if;
  import pcs_ctrl_pkg::*;
  logic               wr_en;
  logic [PTR_W-1:0]   wr_addr;
  logic [ENTRY_W-1:0] wr_data;
  logic [PTR_W-1:0]   rd_addr;
  logic [ENTRY_W-1:0] rd_data;
  modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
  modport user  (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
endinterface

// *** common/pcs_ctrl_pkg.sv ***
// Purpose: shared constants and types for the pcs mode, rate and compensation block
// Assumes: 20 MHz core clock; rate pacing is scaled to that clock
// Notes:   all offsets, field positions, reset values and timing counts live here
package pcs_ctrl_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_STATUS = 8'h04;
  localparam logic [7:0]  OFF_FIFO   = 8'h08;
  localparam logic [7:0]  OFF_THRESH = 8'h0C;

  // control word fields (byte lane 0)
  localparam int          CTRL_GBE     = 0;
  localparam int          CTRL_PHY     = 1;
  localparam int          CTRL_RATE_LO = 2;
  localparam int          CTRL_DBG     = 4;
  localparam int          CTRL_AN_EN   = 5;
  localparam int          CTRL_RESTART = 6;
  localparam int          CTRL_SINGLE  = 7;
  localparam logic [7:0]  CTRL_RESET   = 8'h28;

  // status and threshold field positions
  localparam int          STAT_STATE_LO = 1;
  localparam int          STAT_SYNC     = 4;
  localparam int          THR_HIGH_LO   = 16;

  // ==========================================================================
  // rate adaptation codes
  localparam logic [1:0]  RATE_1G   = 2'b10;
  localparam logic [1:0]  RATE_100M = 2'b01;
  localparam logic [1:0]  RATE_10M  = 2'b00;

  // core cycles per transferred byte at each rate, scaled to the core clock
  localparam logic [6:0]  PACE_1G   = 7'h01;
  localparam logic [6:0]  PACE_100M = 7'h0A;
  localparam logic [6:0]  PACE_10M  = 7'h64;

  typedef enum logic [1:0] {
    CTC_DYNAMIC = 2'b00,
    CTC_STATIC  = 2'b01,
    CTC_NONE    = 2'b10
  } ctc_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE        = 3'b000,
    ST_ABILITY     = 3'b001,
    ST_ACK         = 3'b010,
    ST_LINK_OK     = 3'b011,
    ST_DIS_WAIT    = 3'b100,
    ST_DIS_LINK_OK = 3'b101
  } an_state_t;

  // ==========================================================================
  // compensation fifo
  localparam int          FIFO_DEPTH = 1024;
  localparam int          PTR_W      = 10;
  localparam int          OCC_W      = 11;
  localparam int          ENTRY_W    = 9;
  localparam int          IDLE_BIT   = 8;
  localparam logic [OCC_W-1:0] OCC_FULL = 11'h400;

  // thresholds picked per rate in dynamic mode
  localparam logic [9:0]  DYN_LOW_1G    = 10'h004;
  localparam logic [9:0]  DYN_HIGH_1G   = 10'h00E;
  localparam logic [9:0]  DYN_LOW_100M  = 10'h016;
  localparam logic [9:0]  DYN_HIGH_100M = 10'h020;
  localparam logic [9:0]  DYN_LOW_10M   = 10'h0C3;
  localparam logic [9:0]  DYN_HIGH_10M  = 10'h0CD;
  localparam logic [9:0]  STATIC_LOW_DEF  = 10'h010;
  localparam logic [9:0]  STATIC_HIGH_DEF = 10'h020;
  localparam logic [9:0]  NONE_LOW  = 10'h000;
  localparam logic [9:0]  NONE_HIGH = 10'h3FF;

  // ==========================================================================
  // negotiation timing
  localparam int          CLK_MHZ         = 20;
  localparam int          LINK_TIMER_US   = 1600;
  localparam int          LINK_TIMER_CYC  = LINK_TIMER_US * CLK_MHZ;
  localparam int          TIMER_W         = 16;
  localparam logic [15:0] SHORT_TIMER_CYC = 16'h0010;

  // advertised configuration words
  localparam logic [15:0] CFG_1000X    = 16'h0020;
  localparam logic [15:0] CFG_MAC      = 16'h4001;
  localparam logic [15:0] CFG_PHY_BASE = 16'h1001;

endpackage

// *** logic/ctc_fifo_mem.sv ***
// Purpose: storage array for the receive compensation fifo
// Assumes: write and read on the same clock
// Notes:   read data appears one edge after the address
module ctc_fifo_mem (
  // clock
  input wire logic clk_i,
  // storage port
  ctc_fifo_if.store port
);
  import pcs_ctrl_pkg::*;

  logic [ENTRY_W-1:0] mem_reg [FIFO_DEPTH];
  logic [ENTRY_W-1:0] rd_data_reg;

  // ==========================================================================
  // array write and registered read
  always_ff @(posedge clk_i) begin
    if (port.wr_en) begin
      mem_reg[port.wr_addr] <= port.wr_data;
    end
    rd_data_reg <= mem_reg[port.rd_addr];
  end

  assign port.rd_data = rd_data_reg;
endmodule

// *** logic/gbe_sgmii_pcs_mode_rate_ctc.sv ***
// Purpose: mode control, link status, rate pacing and receive compensation
// Assumes: link clock and link data are slow enough to be sampled by clk_i
// Notes:   registers reached over classic wishbone, one-cycle answer
module gbe_sgmii_pcs_mode_rate_ctc #(
  parameter int unsigned           LINK_TIMER_CYCLES = pcs_ctrl_pkg::LINK_TIMER_CYC,
  parameter pcs_ctrl_pkg::ctc_mode_t CTC_MODE        = pcs_ctrl_pkg::CTC_DYNAMIC,
  parameter logic [9:0]            STATIC_LOW        = pcs_ctrl_pkg::STATIC_LOW_DEF,
  parameter logic [9:0]            STATIC_HIGH       = pcs_ctrl_pkg::STATIC_HIGH_DEF
) (
  // clock and resets
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        rst_n_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // receive link side
  input  wire logic        link_clk_i,
  input  wire logic [7:0]  rx_code_i,
  input  wire logic        rx_idle_i,
  input  wire logic        rx_sync_i,
  // mac side
  output logic      [7:0]  rx_data_o,
  output logic             rx_dv_o,
  output logic             rx_strobe_o,
  output logic      [1:0]  rate_o,
  output logic             negotiated_link_good_o,
  output logic      [15:0] adv_config_o
);
  import pcs_ctrl_pkg::*;

  // ==========================================================================
  // decode helpers
  function automatic logic [1:0] eff_rate(input logic gbe, input logic [1:0] req);
    if (gbe || req == 2'b11) begin
      eff_rate = RATE_1G;
    end else begin
      eff_rate = req;
    end
  endfunction

  function automatic logic [6:0] pace_limit(input logic [1:0] rate, input logic nib);
    logic [6:0] full;
    full = (rate == RATE_1G) ? PACE_1G : (rate == RATE_100M) ? PACE_100M : PACE_10M;
    pace_limit = nib ? (full >> 1) : full;
  endfunction

  // ==========================================================================
  // input synchronisers; data and clock share depth so they stay aligned
  logic       rst_n_s1, rst_n_s2, rst_all;
  logic       lclk_s1, lclk_s2, lclk_s3;
  logic [7:0] code_s1, code_s2;
  logic       idle_s1, idle_s2, sync_s1, sync_s2;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_n_s1 <= 1'b0;
      rst_n_s2 <= 1'b0;
    end else begin
      rst_n_s1 <= rst_n_i;
      rst_n_s2 <= rst_n_s1;
    end
    lclk_s1 <= link_clk_i;
    lclk_s2 <= lclk_s1;
    lclk_s3 <= lclk_s2;
    code_s1 <= rx_code_i;
    code_s2 <= code_s1;
    idle_s1 <= rx_idle_i;
    idle_s2 <= idle_s1;
    sync_s1 <= rx_sync_i;
    sync_s2 <= sync_s1;
  end

  assign rst_all = rst_i | ~rst_n_s2;

  // ==========================================================================
  // wishbone register file
  logic [7:0]  ctrl_reg, ctrl_next;
  logic        ack_reg, ack_next, restart_reg, restart_next;
  logic [31:0] dat_reg, dat_next;
  logic [OCC_W-1:0] occ_reg, occ_next;
  logic [9:0]  low_reg, low_next, high_reg, high_next;
  an_state_t   an_state_reg, an_next;
  logic        link_good_reg, link_good_next;
  logic        req;

  assign req = wb_cyc_i & wb_stb_i;

  // write takes effect on the acking edge; read data latched one edge earlier
  always_comb begin
    ctrl_next    = ctrl_reg;
    restart_next = 1'b0;
    ack_next     = req & ~ack_reg;
    dat_next     = dat_reg;
    if (req && ack_reg && wb_we_i && wb_adr_i == OFF_CTRL && wb_sel_i[0]) begin
      ctrl_next               = wb_dat_i[7:0];
      ctrl_next[CTRL_RESTART] = 1'b0; // restart is a pulse, reads back zero
      restart_next            = wb_dat_i[CTRL_RESTART];
    end
    if (req && !ack_reg) begin
      dat_next = 32'h0000_0000; // unmapped addresses read zero
      unique case (wb_adr_i)
        OFF_CTRL:   dat_next[7:0] = ctrl_reg;
        OFF_STATUS: begin
          dat_next[0]                       = link_good_reg;
          dat_next[STAT_STATE_LO +: 3]      = an_state_reg;
          dat_next[STAT_SYNC]               = sync_s2;
        end
        OFF_FIFO:   dat_next[OCC_W-1:0] = occ_reg;
        OFF_THRESH: begin
          dat_next[9:0]                = low_reg;
          dat_next[THR_HIGH_LO +: 10]  = high_reg;
        end
        default:    dat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      ctrl_reg    <= CTRL_RESET;
      ack_reg     <= 1'b0;
      restart_reg <= 1'b0;
      dat_reg     <= 32'h0000_0000;
    end else begin
      ctrl_reg    <= ctrl_next;
      ack_reg     <= ack_next;
      restart_reg <= restart_next;
      dat_reg     <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ==========================================================================
  // mode decode and advertised word
  logic [1:0] rate;
  logic       gbe, phy_role, an_en, dbg, single, nibble;
  logic [15:0] cfg_reg, cfg_next;
  logic [1:0]  rate_reg;

  assign gbe      = ctrl_reg[CTRL_GBE];
  assign phy_role = ctrl_reg[CTRL_PHY];
  assign an_en    = ctrl_reg[CTRL_AN_EN];
  assign dbg      = ctrl_reg[CTRL_DBG];
  assign single   = ctrl_reg[CTRL_SINGLE];
  assign rate     = eff_rate(gbe, ctrl_reg[CTRL_RATE_LO +: 2]);
  assign nibble   = ~single & (rate != RATE_1G);

  // phy-side entity reports link and speed, mac side only acknowledges
  always_comb begin
    if (gbe) begin
      cfg_next = CFG_1000X;
    end else if (phy_role) begin
      cfg_next = CFG_PHY_BASE | {link_good_reg, 3'b000, rate, 10'h000};
    end else begin
      cfg_next = CFG_MAC;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      cfg_reg  <= CFG_MAC;
      rate_reg <= RATE_1G;
    end else begin
      cfg_reg  <= cfg_next;
      rate_reg <= rate;
    end
  end

  assign adv_config_o = cfg_reg;
  assign rate_o       = rate_reg;

  // ==========================================================================
  // negotiation state and link timer
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic               timer_load, timer_done, restart;

  assign timer_done = timer_reg == '0;
  assign restart    = restart_reg;

  always_comb begin
    an_next = an_state_reg;
    unique case (an_state_reg)
      ST_IDLE: begin
        if (!an_en) an_next = ST_DIS_WAIT;
        else if (timer_done) an_next = ST_ABILITY;
      end
      ST_ABILITY: begin
        if (!an_en) an_next = ST_DIS_WAIT;
        else if (restart) an_next = ST_IDLE;
        else if (sync_s2) an_next = ST_ACK;
      end
      ST_ACK: begin
        if (!an_en) an_next = ST_DIS_WAIT;
        else if (restart || !sync_s2) an_next = ST_IDLE;
        else if (timer_done) an_next = ST_LINK_OK;
      end
      ST_LINK_OK: begin
        if (!an_en) an_next = ST_DIS_WAIT;
        else if (restart || !sync_s2) an_next = ST_IDLE;
      end
      ST_DIS_WAIT: begin
        if (an_en) an_next = ST_IDLE;
        else if (sync_s2) an_next = ST_DIS_LINK_OK;
      end
      ST_DIS_LINK_OK: begin
        if (an_en) an_next = ST_IDLE;
        else if (!sync_s2) an_next = ST_DIS_WAIT;
      end
      default: an_next = ST_IDLE;
    endcase
    // timer restarts on every entry into a timed state
    timer_load = (an_next != an_state_reg) && (an_next == ST_IDLE || an_next == ST_ACK);
    if (timer_load) begin
      timer_next = dbg ? SHORT_TIMER_CYC : TIMER_W'(LINK_TIMER_CYCLES);
    end else if (dbg && timer_reg > SHORT_TIMER_CYC) begin
      // a long count already running is cut short as soon as debug is set
      timer_next = SHORT_TIMER_CYC;
    end else begin
      timer_next = timer_done ? timer_reg : timer_reg - 16'h0001;
    end
    link_good_next = an_en ? (an_next == ST_LINK_OK)
                           : (an_next == ST_DIS_LINK_OK);
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      an_state_reg  <= ST_IDLE;
      timer_reg     <= TIMER_W'(LINK_TIMER_CYCLES);
      link_good_reg <= 1'b0;
    end else begin
      an_state_reg  <= an_next;
      timer_reg     <= timer_next;
      link_good_reg <= link_good_next;
    end
  end

  assign negotiated_link_good_o = link_good_reg;

  // ==========================================================================
  // compensation fifo: thresholds, write with idle deletion, paced read
  ctc_fifo_if fifo ();

  ctc_fifo_mem u_mem (
    .clk_i (clk_i),
    .port  (fifo.store)
  );

  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [6:0]       pace_reg, pace_next;
  logic             link_rise, drop, wr, tick, slot, insert, rd;
  logic             phase_reg, phase_next;
  logic             rd_pend_reg, ins_pend_reg, hi_pend_reg;
  logic             use_ctc, prev_idle;
  logic             last_idle_reg, last_idle_next;

  assign use_ctc   = CTC_MODE != CTC_NONE;
  assign link_rise = lclk_s2 & ~lclk_s3;
  assign tick      = pace_reg == 7'h00;
  assign slot      = tick & (~nibble | ~phase_reg);

  // only idles are dropped at the high mark, but a byte of any kind is lost while the fifo holds OCC_FULL entries
  always_comb begin
    unique case (CTC_MODE)
      CTC_STATIC: begin
        low_next  = STATIC_LOW;
        high_next = STATIC_HIGH;
      end
      CTC_NONE: begin
        low_next  = NONE_LOW;
        high_next = NONE_HIGH;
      end
      default: begin
        low_next  = (rate == RATE_1G) ? DYN_LOW_1G
                  : (rate == RATE_100M) ? DYN_LOW_100M : DYN_LOW_10M;
        high_next = (rate == RATE_1G) ? DYN_HIGH_1G
                  : (rate == RATE_100M) ? DYN_HIGH_100M : DYN_HIGH_10M;
      end
    endcase
    drop   = link_rise & use_ctc & idle_s2 & (occ_reg > {1'b0, high_reg});
    wr     = link_rise & ~drop & (occ_reg != OCC_FULL);
    // a read still in flight decides whether the stream sits between frames
    prev_idle = rd_pend_reg ? fifo.rd_data[IDLE_BIT] : last_idle_reg;
    insert = slot & ((occ_reg == '0) |
             (use_ctc & prev_idle & (occ_reg < {1'b0, low_reg})));
    rd     = slot & ~insert;
    occ_next    = occ_reg + OCC_W'(wr) - OCC_W'(rd);
    wr_ptr_next = wr ? wr_ptr_reg + 10'h001 : wr_ptr_reg;
    rd_ptr_next = rd ? rd_ptr_reg + 10'h001 : rd_ptr_reg;
    pace_next   = tick ? pace_limit(rate, nibble) - 7'h01 : pace_reg - 7'h01;
    phase_next  = nibble ? (phase_reg ^ tick) : 1'b0;
  end

  assign fifo.wr_en   = wr;
  assign fifo.wr_addr = wr_ptr_reg;
  assign fifo.wr_data = {idle_s2, code_s2};
  assign fifo.rd_addr = rd_ptr_reg;

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      low_reg      <= NONE_LOW;
      high_reg     <= NONE_HIGH;
      occ_reg      <= '0;
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      pace_reg     <= 7'h00;
      phase_reg    <= 1'b0;
      rd_pend_reg  <= 1'b0;
      ins_pend_reg <= 1'b0;
      hi_pend_reg  <= 1'b0;
    end else begin
      low_reg      <= low_next;
      high_reg     <= high_next;
      occ_reg      <= occ_next;
      wr_ptr_reg   <= wr_ptr_next;
      rd_ptr_reg   <= rd_ptr_next;
      pace_reg     <= pace_next;
      phase_reg    <= phase_next;
      rd_pend_reg  <= rd;
      ins_pend_reg <= insert;
      hi_pend_reg  <= tick & nibble & phase_reg;
    end
  end

  // ==========================================================================
  // mac-side output stage; a nibble pair shares one fetched entry
  logic [7:0] hold_reg, hold_next, out_reg, out_next;
  logic       dv_reg, dv_next, stb_reg, stb_next;

  always_comb begin
    hold_next      = hold_reg;
    last_idle_next = last_idle_reg;
    out_next       = out_reg;
    dv_next        = dv_reg;
    stb_next       = rd_pend_reg | ins_pend_reg | hi_pend_reg;
    if (rd_pend_reg) begin
      hold_next      = fifo.rd_data[7:0];
      last_idle_next = fifo.rd_data[IDLE_BIT];
      dv_next        = ~fifo.rd_data[IDLE_BIT];
      out_next       = nibble ? {4'h0, fifo.rd_data[3:0]} : fifo.rd_data[7:0];
    end else if (ins_pend_reg) begin
      hold_next      = 8'h00;
      last_idle_next = 1'b1;
      dv_next        = 1'b0;
      out_next       = 8'h00;
    end else if (hi_pend_reg) begin
      out_next = {4'h0, hold_reg[7:4]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      hold_reg      <= 8'h00;
      last_idle_reg <= 1'b1;
      out_reg       <= 8'h00;
      dv_reg        <= 1'b0;
      stb_reg       <= 1'b0;
    end else begin
      hold_reg      <= hold_next;
      last_idle_reg <= last_idle_next;
      out_reg       <= out_next;
      dv_reg        <= dv_next;
      stb_reg       <= stb_next;
    end
  end

  assign rx_data_o   = out_reg;
  assign rx_dv_o     = dv_reg;
  assign rx_strobe_o = stb_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_all);

  sequence s_ack_done;
    an_state_reg == ST_ACK && timer_done && sync_s2 && an_en && !restart;
  endsequence

  property p_link_ok;
    s_ack_done |=> an_state_reg == ST_LINK_OK && link_good_reg;
  endproperty
  a_link_ok: assert property (p_link_ok) else $error("link ok not reported");

  property p_link_dis;
    an_state_reg == ST_DIS_LINK_OK |-> link_good_reg;
  endproperty
  a_link_dis: assert property (p_link_dis) else $error("disabled link ok wrong");

  property p_good_only;
    link_good_reg |-> an_state_reg == ST_LINK_OK || an_state_reg == ST_DIS_LINK_OK;
  endproperty
  a_good_only: assert property (p_good_only) else $error("link good in wrong state");

  property p_reset;
    @(posedge clk_i) disable iff (rst_i) $fell(rst_n_s2) |=> an_state_reg == ST_IDLE
      && !link_good_reg && occ_reg == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("global reset ignored");

  property p_role;
    !gbe && !phy_role |=> cfg_reg == CFG_MAC;
  endproperty
  a_role: assert property (p_role) else $error("mac role word wrong");

  property p_gbe;
    gbe |=> cfg_reg == CFG_1000X && rate_reg == RATE_1G;
  endproperty
  a_gbe: assert property (p_gbe) else $error("gigabit mode not forced");

  property p_rate;
    !gbe && ctrl_reg[CTRL_RATE_LO +: 2] == RATE_100M |=> rate_reg == RATE_100M;
  endproperty
  a_rate: assert property (p_rate) else $error("100 mbps not selected");

  property p_debug;
    timer_load && dbg |=> timer_reg == SHORT_TIMER_CYC;
  endproperty
  a_debug: assert property (p_debug) else $error("short timer not loaded");

  property p_static;
    CTC_MODE == CTC_STATIC |=> low_reg == STATIC_LOW && high_reg == STATIC_HIGH;
  endproperty
  a_static: assert property (p_static) else $error("static thresholds moved");

  property p_none;
    CTC_MODE == CTC_NONE |-> !drop && (!insert || occ_reg == '0);
  endproperty
  a_none: assert property (p_none) else $error("none mode altered stream");

  property p_delete;
    drop |-> idle_s2 && occ_reg > {1'b0, high_reg} ##1 occ_reg <= $past(occ_reg);
  endproperty
  a_delete: assert property (p_delete) else $error("bad idle deletion");

  property p_depth;
    occ_reg <= OCC_FULL;
  endproperty
  a_depth: assert property (p_depth) else $error("fifo overfilled");
endmodule

// *** verification/gbe_sgmii_pcs_mode_rate_ctc_bench.sv ***
// Purpose: self-checking bench for the pcs mode, rate and compensation block
// Assumes: wishbone answers one cycle after it takes a request
// Notes:   link timer kept long, so only the debug bit negotiates quickly
module gbe_sgmii_pcs_mode_rate_ctc_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pcs_ctrl_pkg::*;
  logic        clk_i, rst_i, rst_n_i, cyc, stb, we, ack, lclk, idle, sync, good, dv, stb_o;
  logic [7:0]  adr, code, cnt, rdata;
  logic [31:0] wdat, q, rdat, last;
  logic [1:0]  rate;
  logic [15:0] adv;
  int          err_count = 0;
  int          tests_run = 0;
  logic [1:0]  codes [3] = '{RATE_1G, RATE_100M, RATE_10M};
  logic [31:0] thr [3] = '{32'h000E0004, 32'h00200016, 32'h00CD00C3};

  // ==========================================================================
  // design and mac model
  // static thresholds kept inside the slip margins an integrator must honour
  gbe_sgmii_pcs_mode_rate_ctc #(
    .LINK_TIMER_CYCLES(4000),
    .STATIC_LOW       (STATIC_LOW_DEF),
    .STATIC_HIGH      (STATIC_HIGH_DEF)
  ) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link_clk_i(lclk), .rx_code_i(code), .rx_idle_i(idle),
    .rx_sync_i(sync), .rx_data_o(rdata), .rx_dv_o(dv), .rx_strobe_o(stb_o),
    .rate_o(rate), .negotiated_link_good_o(good), .adv_config_o(adv));
  mac_rx_model i_mac (.clk_i(clk_i), .rst_i(rst_i), .rx_data_i(rdata), .rx_dv_i(dv),
    .rx_strobe_i(stb_o), .last_o(last), .count_o(cnt));

  // ==========================================================================
  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    end_sim();
  end

  // ==========================================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle, request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_good(input int lim);
    int n;
    n = 0;
    while (good !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check("link good", {31'h0, good}, 32'h1);
  endtask
  // one link byte per 400 ns; bytes 6 to 9 form a four byte frame
  task automatic send_frame(input int n);
    for (int i = 0; i < n; i++) begin
      code <= (i > 5 && i < 10) ? 8'(32'hA53C0FF0 >> (8 * (9 - i))) : 8'hBC;
      idle <= !(i > 5 && i < 10);
      repeat (4) @(posedge clk_i);
      lclk <= 1'b1;
      repeat (4) @(posedge clk_i);
      lclk <= 1'b0;
    end
    repeat (40) @(posedge clk_i);
  endtask
  // global reset pulse; link must fall and control return to its reset value
  task automatic pulse_rst_n();
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("link in reset", {31'h0, good}, 32'h0);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    wb(1'b0, OFF_CTRL, 32'h0, q);
    check("ctrl after reset", q, 32'h28);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // test sequence
  initial begin
    {rst_i, rst_n_i, sync, idle} = 4'hF;
    {cyc, stb, we, lclk, adr, code, wdat} = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, OFF_CTRL, 32'h0, q);
    check("ctrl reset", q, 32'h28);
    wb(1'b0, 8'h10, 32'h0, q);
    check("unmapped", q, 32'h0);
    check("rate reset", {30'h0, rate}, {30'h0, RATE_1G});
    check("adv mac", {16'h0, adv}, 32'h4001);
    $display("test reset done");
    // every speed code, then the same code under gigabit mode
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, OFF_CTRL, {28'h0, codes[k], 2'b00}, q);
      wb(1'b0, OFF_THRESH, 32'h0, q);
      check("thresholds", q, thr[k]);
      check("rate sgmii", {30'h0, rate}, {30'h0, codes[k]});
      wb(1'b1, OFF_CTRL, {28'h0, codes[k], 2'b01}, q);
      wb(1'b0, OFF_STATUS, 32'h0, q);
      check("rate gbe", {30'h0, rate}, {30'h0, RATE_1G});
      check("adv gbe", {16'h0, adv}, 32'h0020);
    end
    wb(1'b1, OFF_CTRL, 32'h06, q);
    wb(1'b0, OFF_STATUS, 32'h0, q);
    check("adv phy", {17'h0, adv[14:0]}, 32'h1401);
    $display("test modes done");
    pulse_rst_n();
    wb(1'b1, OFF_CTRL, 32'h38, q);
    wait_good(300);
    wb(1'b0, OFF_STATUS, 32'h0, q);
    check("an state on", {29'h0, q[3:1]}, 32'h3);
    pulse_rst_n();
    wb(1'b1, OFF_CTRL, 32'h08, q);
    wait_good(10000);
    wb(1'b0, OFF_STATUS, 32'h0, q);
    check("an state off", {29'h0, q[3:1]}, 32'h5);
    $display("test link done");
    // idles, a four byte frame, idles, at full rate in single-clock style
    wb(1'b1, OFF_CTRL, 32'h88, q);
    send_frame(22);
    check("frame bytes", last, 32'hA53C0FF0);
    check("frame count", {24'h0, cnt}, 32'h4);
    check("dv after frame", {31'h0, dv}, 32'h0);
    // classic style at 100 mbps: low nibble, then high nibble of each byte
    wb(1'b1, OFF_CTRL, 32'h04, q);
    send_frame(40);
    check("nibble bytes", last, 32'h0F00000F);
    check("nibble count", {24'h0, cnt}, 32'hC);
    check("dv after nibbles", {31'h0, dv}, 32'h0);
    $display("test data done");
    end_sim();
  end
endmodule

// *** verification/mac_rx_model.sv ***
// Purpose: mac side receiver model for the pcs block
// Assumes: the strobe marks every updated output byte
// Notes:   keeps only the last four frame bytes and a count
module mac_rx_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // receive port
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_dv_i,
  input  wire logic        rx_strobe_i,
  // history seen
  output logic      [31:0] last_o,
  output logic      [7:0]  count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // take a sample only on the enable; at 10 and 100 mbps in classic style each one is a zero-padded nibble
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_o  <= 32'h0;
      count_o <= 8'h00;
    end else if (rx_strobe_i && rx_dv_i) begin
      last_o  <= {last_o[23:0], rx_data_i};
      count_o <= count_o + 8'h01;
    end
  end
endmodule
